// *** pkg/eeprom_prot_pkg.sv ***
package eeprom_prot_pkg;
	// clock rate of ref_clk
	localparam int CLK_MHZ = 40;
	// density and organisation of the array served by this block
	localparam int DENSITY_KBIT = 512;
	localparam int ADDR_BITS    = 16;
	localparam int PAGE_BITS    = 8;
	// density-dependent features
	localparam bit SMALL_PART     = (DENSITY_KBIT <= 4);
	localparam bit PIN_EN_PRESENT = (DENSITY_KBIT >= 8);
	localparam bit ERASE_PRESENT  = (DENSITY_KBIT >= 512);
	// instruction opcodes, sent msb first
	localparam logic [7:0] OP_LATCH_SET   = 8'h06;
	localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] OP_STATUS_RD   = 8'h05;
	localparam logic [7:0] OP_STATUS_WR   = 8'h01;
	localparam logic [7:0] OP_PAGE_ERASE  = 8'h42;
	// status byte field positions
	localparam int BIT_PIN_EN  = 7;
	localparam int BIT_BP_HI   = 3;
	localparam int BIT_BP_LO   = 2;
	localparam int BIT_LATCH   = 1;
	localparam int BIT_BUSY    = 0;
	// power-up values of the stored bits
	localparam logic       PIN_EN_RST = 1'b0;
	localparam logic [1:0] BP_RST     = 2'b00;
	localparam logic       LATCH_RST  = 1'b0;
	// exact frame lengths in serial clocks, and the clock count ceiling
	localparam logic [4:0] LEN_CMD      = 5'h08;
	localparam logic [4:0] LEN_STAT_WR  = 5'h10;
	localparam logic [4:0] LEN_ERASE    = 5'h18;
	localparam logic [4:0] CNT_MAX      = 5'h1F;
	// self-timed cycle durations
	localparam int T_STAT_WR_US    = 5000;
	localparam int T_PAGE_ERASE_US = 6000;
	localparam int STAT_WR_CYCLES    = T_STAT_WR_US * CLK_MHZ;
	localparam int PAGE_ERASE_CYCLES = T_PAGE_ERASE_US * CLK_MHZ;
	localparam int TIMER_W           = 18;
	// serial frame progress
	typedef enum logic [1:0] {
		FR_IDLE    = 2'b00,
		FR_ACTIVE  = 2'b01,
		FR_READOUT = 2'b10
	} frame_e;
	// internal self-timed cycle
	typedef enum logic [1:0] {
		CYC_IDLE    = 2'b00,
		CYC_STAT_WR = 2'b01,
		CYC_ERASE   = 2'b10
	} cycle_e;
endpackage

// *** logic/eeprom_write_protect_status.sv ***
`timescale 1ns/1ps
module eeprom_write_protect_status #(
	parameter int STAT_WR_CYCLES    = eeprom_prot_pkg::STAT_WR_CYCLES,
	parameter int PAGE_ERASE_CYCLES = eeprom_prot_pkg::PAGE_ERASE_CYCLES
) (
	input  wire logic                                 ref_clk,
	input  wire logic                                 arst_n,
	input  wire logic                                 cs_n,
	input  wire logic                                 sck,
	input  wire logic                                 si,
	input  wire logic                                 wp_n,
	input  wire logic                                 arr_busy,
	input  wire logic                                 arr_write_done,
	output logic                                      so,
	output logic                                      so_oe_n,
	output logic                                      busy,
	output logic                                      latch_state,
	output logic                                      pin_protect_enable,
	output logic [1:0]                                block_protect,
	output logic                                      erase_go,
	output logic [eeprom_prot_pkg::PAGE_BITS-1:0]     erase_page
);

	localparam int AW = eeprom_prot_pkg::ADDR_BITS;

	// reset release chain
	logic                        rst_meta_ff;   // first stage, read only by second
	logic                        rst_n;         // released reset used everywhere
	// pin history for edge detection
	logic                        cs_prev_ff;    // chip select last cycle
	logic                        sck_prev_ff;   // serial clock last cycle
	logic                        sel_ff;        // selected after a proper fall
	// serial frame state
	eeprom_prot_pkg::frame_e     frame_ff;      // frame progress
	logic [4:0]                  bit_cnt_ff;    // clocks seen in this frame
	logic [23:0]                 shift_ff;      // incoming bits, msb first
	logic [7:0]                  opcode_ff;     // captured instruction
	logic [2:0]                  out_idx_ff;    // next status bit to send
	// stored bits
	logic                        latch_ff;      // write enable latch
	logic                        pin_en_ff;     // pin-protect enable
	logic [1:0]                  bp_ff;         // block-protect pair
	logic [7:0]                  sr_pend_ff;    // status byte awaiting commit
	// self-timed cycle
	eeprom_prot_pkg::cycle_e     cyc_ff;        // running cycle kind
	logic [eeprom_prot_pkg::TIMER_W-1:0] timer_ff; // cycles left
	// output registers
	logic                        so_ff;
	logic                        so_oe_n_ff;
	logic                        busy_ff;
	logic                        erase_go_ff;
	logic [eeprom_prot_pkg::PAGE_BITS-1:0] erase_page_ff;

	// decoded events
	logic       cs_fall;        // chip select high to low
	logic       cs_rise;        // end of a selected frame
	logic       sck_rise;       // sampling edge
	logic       sck_fall;       // shifting-out edge
	logic       cyc_active;     // internal cycle running
	logic       cyc_done;       // last cycle of internal cycle
	logic       hw_prot;        // pin protection in force
	logic       set_req;        // valid latch-set frame
	logic       clr_req;        // valid latch-clear frame
	logic       sr_req;         // well-formed status write frame
	logic       sr_start;       // status write accepted
	logic       er_req;         // well-formed page erase frame
	logic       er_prot;        // addressed page protected
	logic       er_start;       // page erase accepted
	logic [7:0] stat_byte;      // live status byte
	logic [AW-1:0] er_addr;     // address of erase frame

	// quarter check, scales with address width
	function automatic logic addr_protected(input logic [AW-1:0] a, input logic [1:0] bp);
		logic hit;
		hit = 1'b0;
		unique case (bp)
			2'b00: hit = 1'b0;
			2'b01: hit = (a[AW-1 -: 2] == 2'b11);
			2'b10: hit = a[AW-1];
			2'b11: hit = 1'b1;
		endcase
		return hit;
	endfunction

	// two-stage release of the asynchronous reset
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_ff <= 1'b0;
			rst_n       <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n       <= rst_meta_ff;
		end
	end

	// pin edge decode; inputs are synchronous to ref_clk
	assign cs_fall  = cs_prev_ff && !cs_n;
	assign cs_rise  = !cs_prev_ff && cs_n && sel_ff;
	assign sck_rise = !sck_prev_ff && sck && sel_ff && !cs_n;
	assign sck_fall = sck_prev_ff && !sck && sel_ff && !cs_n;

	assign stat_byte = {pin_en_ff & eeprom_prot_pkg::PIN_EN_PRESENT, 3'b000,
		bp_ff, latch_ff, busy_ff};

	assign hw_prot = !wp_n && pin_en_ff && eeprom_prot_pkg::PIN_EN_PRESENT;

	assign cyc_active = (cyc_ff != eeprom_prot_pkg::CYC_IDLE);
	assign cyc_done   = cyc_active && (timer_ff == '0);
	assign er_addr    = shift_ff[AW-1:0];

	assign set_req = cs_rise && !busy_ff && opcode_ff == eeprom_prot_pkg::OP_LATCH_SET
		&& bit_cnt_ff == eeprom_prot_pkg::LEN_CMD;
	assign clr_req = cs_rise && !busy_ff && opcode_ff == eeprom_prot_pkg::OP_LATCH_CLEAR
		&& bit_cnt_ff == eeprom_prot_pkg::LEN_CMD;
	// status write only on exact rise, never while busy
	assign sr_req = cs_rise && !busy_ff && opcode_ff == eeprom_prot_pkg::OP_STATUS_WR
		&& bit_cnt_ff == eeprom_prot_pkg::LEN_STAT_WR;
	// pin protection refuses status write only
	assign sr_start = sr_req && latch_ff && !hw_prot;
	// erase opcode on large parts, exact end
	assign er_req = cs_rise && !busy_ff && eeprom_prot_pkg::ERASE_PRESENT
		&& opcode_ff == eeprom_prot_pkg::OP_PAGE_ERASE
		&& bit_cnt_ff == eeprom_prot_pkg::LEN_ERASE;
	assign er_prot = addr_protected(er_addr, bp_ff);
	// erase requires latch; protected page aborts
	assign er_start = er_req && latch_ff && !er_prot;

	// pin history and selection; reset value forces a fresh fall first
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_prev_ff  <= 1'b0;
			sck_prev_ff <= 1'b0;
			sel_ff      <= 1'b0;
		end else begin
			cs_prev_ff  <= cs_n;
			sck_prev_ff <= sck;
			// select only on high-to-low chip select
			if (cs_fall) begin
				sel_ff <= 1'b1;
			end else if (cs_n) begin
				sel_ff <= 1'b0;
			end
		end
	end

	// serial frame: bit count, input shift, opcode capture
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_ff   <= eeprom_prot_pkg::FR_IDLE;
			bit_cnt_ff <= 5'h00;
			shift_ff   <= 24'h00_0000;
			opcode_ff  <= 8'h00;
			out_idx_ff <= 3'h7;
		end else if (cs_fall) begin
			// new frame
			frame_ff   <= eeprom_prot_pkg::FR_ACTIVE;
			bit_cnt_ff <= 5'h00;
			opcode_ff  <= 8'h00;
			out_idx_ff <= 3'h7;
		end else if (cs_n) begin
			// deselected
			frame_ff <= eeprom_prot_pkg::FR_IDLE;
		end else if (sck_rise) begin
			// msb arrives first, shifts toward the top
			shift_ff <= {shift_ff[22:0], si};
			if (bit_cnt_ff != eeprom_prot_pkg::CNT_MAX) begin
				bit_cnt_ff <= bit_cnt_ff + 5'h01;
			end
			if (bit_cnt_ff == eeprom_prot_pkg::LEN_CMD - 5'h01) begin
				opcode_ff <= {shift_ff[6:0], si};
				// status read enters readout after opcode
				if ({shift_ff[6:0], si} == eeprom_prot_pkg::OP_STATUS_RD) begin
					frame_ff <= eeprom_prot_pkg::FR_READOUT;
				end
			end
		end else if (sck_fall && frame_ff == eeprom_prot_pkg::FR_READOUT) begin
			// walk the status byte; wraps to repeat it
			out_idx_ff <= out_idx_ff - 3'h1;
		end
	end

	// status bits shift out on falling edges, even while busy
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			so_ff      <= 1'b0;
			so_oe_n_ff <= 1'b1;
		end else if (cs_n) begin
			so_oe_n_ff <= 1'b1;
		end else if (sck_fall && frame_ff == eeprom_prot_pkg::FR_READOUT) begin
			so_ff      <= stat_byte[out_idx_ff];
			so_oe_n_ff <= 1'b0;
		end
	end

	// write enable latch
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_ff <= eeprom_prot_pkg::LATCH_RST;
		end else if (cyc_done || arr_write_done) begin
			// completion of a write or erase clears latch
			latch_ff <= 1'b0;
		end else if (eeprom_prot_pkg::SMALL_PART && !wp_n) begin
			// low protect pin clears latch on small parts
			latch_ff <= 1'b0;
		end else if (set_req) begin
			latch_ff <= 1'b1;
		end else if (clr_req) begin
			latch_ff <= 1'b0;
		end
	end

	// self-timed cycle sequencer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_ff     <= eeprom_prot_pkg::CYC_IDLE;
			timer_ff   <= '0;
			sr_pend_ff <= 8'h00;
		end else if (cyc_active) begin
			if (cyc_done) begin
				cyc_ff <= eeprom_prot_pkg::CYC_IDLE;
			end else begin
				timer_ff <= timer_ff - 1'b1;
			end
		end else if (sr_start) begin
			// status write runs its own timed cycle
			cyc_ff     <= eeprom_prot_pkg::CYC_STAT_WR;
			timer_ff   <= eeprom_prot_pkg::TIMER_W'(STAT_WR_CYCLES - 1);
			sr_pend_ff <= shift_ff[7:0];
		end else if (er_start) begin
			// erase starts on the chip-select rise
			cyc_ff   <= eeprom_prot_pkg::CYC_ERASE;
			timer_ff <= eeprom_prot_pkg::TIMER_W'(PAGE_ERASE_CYCLES - 1);
		end
	end

	// stored protection bits, committed when the status write completes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_en_ff <= eeprom_prot_pkg::PIN_EN_RST;
			bp_ff     <= eeprom_prot_pkg::BP_RST;
		end else if (cyc_done && cyc_ff == eeprom_prot_pkg::CYC_STAT_WR) begin
			// only a status write changes the protect bits
			bp_ff <= {sr_pend_ff[eeprom_prot_pkg::BIT_BP_HI],
				sr_pend_ff[eeprom_prot_pkg::BIT_BP_LO]};
			// enable bit exists only on larger parts
			pin_en_ff <= sr_pend_ff[eeprom_prot_pkg::BIT_PIN_EN]
				& eeprom_prot_pkg::PIN_EN_PRESENT;
		end
	end

	// busy flag register, includes the external array writer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_ff <= 1'b0;
		end else begin
			// one while any internal write runs
			busy_ff <= (cyc_active && !cyc_done) || sr_start || er_start || arr_busy;
		end
	end

	// erase request toward the array
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			erase_go_ff   <= 1'b0;
			erase_page_ff <= '0;
		end else begin
			erase_go_ff <= er_start;
			if (er_start) begin
				// low address bits ignored, page index only
				erase_page_ff <= er_addr[AW-1 -: eeprom_prot_pkg::PAGE_BITS];
			end
		end
	end

	assign so                 = so_ff;
	assign so_oe_n            = so_oe_n_ff;
	assign busy               = busy_ff;
	assign latch_state        = latch_ff;
	assign pin_protect_enable = pin_en_ff;
	assign block_protect      = bp_ff;
	assign erase_go           = erase_go_ff;
	assign erase_page         = erase_page_ff;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_latch_set_frame: assert property (
		set_req && !cyc_done && !arr_write_done
			&& !(eeprom_prot_pkg::SMALL_PART && !wp_n) |=> latch_ff && stat_byte[1])
		else $error("latch not set after latch-set frame");

	a_latch_clear_frame: assert property (
		clr_req |=> !latch_ff)
		else $error("latch not cleared after latch-clear frame");

	a_start_needs_latch: assert property (
		cs_rise && !latch_ff && !cyc_active |=> !cyc_active && !erase_go_ff)
		else $error("internal cycle started without latch");

	a_done_clears_latch: assert property (
		cyc_done |=> !latch_ff ##1 !cyc_active)
		else $error("latch survived cycle completion");

	a_busy_during_cycle: assert property (
		er_start |=> (busy_ff && stat_byte[0])[*8])
		else $error("busy flag low during erase");

	a_bp_only_by_write: assert property (
		!$stable(bp_ff) |-> $past(cyc_ff) == eeprom_prot_pkg::CYC_STAT_WR && $past(cyc_done))
		else $error("block-protect bits changed without status write");

	a_pin_refuses_write: assert property (
		sr_req && hw_prot && !cyc_active |=> !cyc_active)
		else $error("status write accepted under pin protection");

	a_protected_abort: assert property (
		er_req && er_prot |=> !erase_go_ff && !busy_ff throughout ##1 1'b1)
		else $error("erase issued to a protected page");

	a_out_released: assert property (
		cs_n |=> so_oe_n)
		else $error("serial output driven while deselected");

	a_ignore_when_busy: assert property (
		cyc_active && !cyc_done |=> $stable(cyc_ff) && !erase_go_ff)
		else $error("running cycle disturbed");

endmodule

// *** test/spi_host_model.sv ***
`timescale 1ns/1ps
// host side of the serial link: opens frames, clocks bits, reads the reply
module spi_host_model (
	input  wire logic ref_clk,
	input  wire logic so,
	input  wire logic so_oe_n,
	output logic      cs_n,
	output logic      sck,
	output logic      si
);
	// idle link: deselected, clock parked low
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end
	// wait a number of ref_clk edges
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// one serial clock: two cycles low, two cycles high
	task automatic pulse();
		tick(2);
		sck <= 1'b1;
		tick(2);
		sck <= 1'b0;
	endtask
	// one frame: nbits sent from word, then nread bits taken from so
	task automatic run(input logic [23:0] word, input int nbits, input int nread,
		output logic [7:0] rd);
		rd = 8'h00;
		@(posedge ref_clk);
		cs_n <= 1'b0;
		for (int i = nbits - 1; i >= 0; i--) begin
			si <= word[i];
			pulse();
		end
		// reply bit settles one cycle after the fall is seen, sample later
		for (int i = 0; i < nread; i++) begin
			tick(3);
			rd = {rd[6:0], so};
			sck <= 1'b1;
			tick(2);
			sck <= 1'b0;
		end
		// select rises right after the last bit
		tick(2);
		cs_n <= 1'b1;
		// released data line no longer shows the last bit
		si <= ~si;
		tick(3);
	endtask
endmodule

// *** test/eeprom_write_protect_status_tb.sv ***
`timescale 1ns/1ps
// bench for the latch, status and protection block
module eeprom_write_protect_status_tb;
	// shortened self-timed cycles
	localparam int STAT_CYC  = 200;
	localparam int ERASE_CYC = 300;
	// latch-set frame
	localparam logic [23:0] SET = 24'h00_0006;
	// table row: frame sent and latch expected after it
	typedef struct packed {
		logic [23:0] word;
		int          nbits;
		logic        latch;
	} row_s;
	logic        ref_clk        = 1'b0;
	logic        arst_n         = 1'b0;
	logic        wp_n           = 1'b1;
	logic        arr_busy       = 1'b0;
	logic        arr_write_done = 1'b0;
	logic        cs_n;
	logic        sck;
	logic        si;
	logic        so;
	logic        so_oe_n;
	logic        busy;
	logic        latch_state;
	logic        pin_protect_enable;
	logic [1:0]  block_protect;
	logic        erase_go;
	logic [7:0]  erase_page;
	logic [7:0]  rd;
	logic [7:0]  go_cnt         = 8'h00;
	int          err_count      = 0;
	int          comparisons    = 0;
	// latch frames, correct and with wrong clock counts
	row_s        rows [8]       = '{
		'{SET, 8, 1'b1}, '{24'h00_0004, 8, 1'b0}, '{24'h00_000C, 9, 1'b0},
		'{24'h00_0003, 7, 1'b0}, '{SET, 8, 1'b1}, '{SET, 8, 1'b1},
		'{24'h00_0002, 7, 1'b1}, '{24'h00_0004, 8, 1'b0}};
	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;
	eeprom_write_protect_status #(
		.STAT_WR_CYCLES    (STAT_CYC),
		.PAGE_ERASE_CYCLES (ERASE_CYC)
	) i_dut (
		.ref_clk            (ref_clk),
		.arst_n             (arst_n),
		.cs_n               (cs_n),
		.sck                (sck),
		.si                 (si),
		.wp_n               (wp_n),
		.arr_busy           (arr_busy),
		.arr_write_done     (arr_write_done),
		.so                 (so),
		.so_oe_n            (so_oe_n),
		.busy               (busy),
		.latch_state        (latch_state),
		.pin_protect_enable (pin_protect_enable),
		.block_protect      (block_protect),
		.erase_go           (erase_go),
		.erase_page         (erase_page)
	);
	spi_host_model i_host (
		.ref_clk (ref_clk),
		.so      (so),
		.so_oe_n (so_oe_n),
		.cs_n    (cs_n),
		.sck     (sck),
		.si      (si)
	);
	// counts accepted erase pulses
	always @(posedge ref_clk) begin
		if (erase_go === 1'b1) begin
			go_cnt <= go_cnt + 8'h01;
		end
	end
	// compare and count
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic frm(input logic [23:0] word, input int nbits);
		i_host.run(word, nbits, 0, rd);
	endtask
	// status read, unused bits masked off
	task automatic st(input logic [7:0] exp);
		i_host.run(24'h00_0005, 8, 8, rd);
		chk("status", exp, rd & 8'h8F);
		chk("so_oe_n", 8'h01, {7'h00, so_oe_n});
	endtask
	// bounded wait for the self-timed cycle, then check busy is low
	task automatic idle();
		for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge ref_clk);
		tick(2);
		chk("idle", 8'h00, {7'h00, busy});
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		tick(40000);
		err_count++;
		stop_test();
	end
	// main sequence
	initial begin
		tick(12);
		arst_n <= 1'b1;
		tick(4);
		chk("reset", 8'h00, {2'b00, busy, latch_state, pin_protect_enable, block_protect,
			erase_go});
		st(8'h00);
		$display("test reset done");
		for (int r = 0; r < 8; r++) begin
			frm(rows[r].word, rows[r].nbits);
			chk("latch", {7'h00, rows[r].latch}, {7'h00, latch_state});
			st({6'h00, rows[r].latch, 1'b0});
		end
		$display("test table done");
		frm(SET, 8);
		frm(24'h00_018D, 16);
		chk("busy", 8'h01, {7'h00, busy});
		st(8'h03);
		idle();
		chk("bp", 8'h03, {6'h00, block_protect});
		st(8'h8C);
		chk("pin_en", 8'h01, {7'h00, pin_protect_enable});
		frm(24'h00_0100, 16);
		st(8'h8C);
		$display("test status write done");
		frm(SET, 8);
		frm(24'h42_1234, 24);
		chk("go", 8'h00, go_cnt);
		st(8'h8E);
		wp_n <= 1'b0;
		tick(3);
		frm(24'h00_0100, 16);
		st(8'h8E);
		wp_n <= 1'b1;
		frm(24'h00_0104, 16);
		idle();
		st(8'h04);
		frm(SET, 8);
		frm(24'h42_C000, 24);
		chk("go", 8'h00, go_cnt);
		frm(24'h42_BFFF, 24);
		chk("go", 8'h01, go_cnt);
		chk("page", 8'hBF, erase_page);
		frm(24'h00_0004, 8);
		st(8'h07);
		idle();
		st(8'h04);
		$display("test erase done");
		wp_n <= 1'b0;
		tick(3);
		frm(SET, 8);
		frm(24'h00_0108, 16);
		idle();
		st(8'h08);
		frm(SET, 8);
		frm(24'h42_8000, 24);
		chk("go", 8'h01, go_cnt);
		frm(24'h42_7F00, 24);
		chk("go", 8'h02, go_cnt);
		chk("page", 8'h7F, erase_page);
		idle();
		$display("test pin protect done");
		frm(SET, 8);
		arr_busy <= 1'b1;
		tick(2);
		chk("busy", 8'h01, {7'h00, busy});
		arr_write_done <= 1'b1;
		tick(1);
		arr_write_done <= 1'b0;
		arr_busy       <= 1'b0;
		tick(3);
		chk("latch", 8'h00, {7'h00, latch_state});
		idle();
		$display("test array write done");
		// reset in mid-run, while a status write cycle runs
		frm(SET, 8);
		frm(24'h00_018C, 16);
		chk("busy", 8'h01, {7'h00, busy});
		arst_n <= 1'b0;
		tick(12);
		chk("reset", 8'h00, {2'b00, busy, latch_state, pin_protect_enable, block_protect,
			erase_go});
		arst_n <= 1'b1;
		tick(2);
		chk("release", 8'h00, {2'b00, busy, latch_state, pin_protect_enable, block_protect,
			erase_go});
		tick(2);
		st(8'h00);
		$display("test mid-run reset done");
		stop_test();
	end
endmodule
